// >>> hw/scmc_params.svh
// Register map, field positions, reset values and timing counts of the clock mode control block.
// Assumes a 20 MHz CLOCK and a 32-bit AXI4-Lite register bus.
`ifndef SCMC_PARAMS_SVH
`define SCMC_PARAMS_SVH
// ****************************************************************
// Register offsets
// ****************************************************************
`define SCMC_OFS_SYSCLK 4'h0
`define SCMC_OFS_FASTRC 4'h4
`define SCMC_OFS_IRQ_STATUS 4'h8
`define SCMC_OFS_IRQ_MASK 4'hC
// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define SCMC_SYSCLK_SEL_LSB 5
`define SCMC_SYSCLK_FAST_KEEP 1
`define SCMC_SYSCLK_SLOW_KEEP 0
`define SCMC_FASTRC_FREQ_LSB 2
`define SCMC_FASTRC_STABLE 1
`define SCMC_FASTRC_ENABLE 0
`define SCMC_SYSCLK_RESET 8'h00
`define SCMC_SEL_SUB 3'h7
`define SCMC_IRQ_STABLE 0
`define SCMC_IRQ_WAKE 1
`define SCMC_IRQ_BITS 2
// ****************************************************************
// Timing
// ****************************************************************
`define SCMC_CLK_MHZ 20
`define SCMC_SETTLE_US 16
`define SCMC_SETTLE_CYC (`SCMC_SETTLE_US * `SCMC_CLK_MHZ)
`endif

// >>> hw/scmc_pkg.sv
// Types shared by the clock mode control block.
// Assumes nothing beyond the constants header.
package scmc_pkg;
    // Operating modes, Gray coded along run, halt and wake.
    typedef enum logic [2:0] {
        SCMC_FAST = 3'h0,
        SCMC_SLOW = 3'h1,
        SCMC_IDLE_SUB = 3'h3,
        SCMC_IDLE_BOTH = 3'h2,
        SCMC_IDLE_FAST = 3'h6,
        SCMC_SLEEP = 3'h7
    } scmc_mode_t;
endpackage

// >>> hw/scmc_top.sv
// Clock selection and power mode control with an AXI4-Lite register slave.
// Assumes a single 20 MHz clock; oscillator and gated clocks are modelled as enables.
//
// Notes on behaviour
// - Select codes 0 to 6 pick fast clock divided by 1..64; 7 picks subclock.
// - Fast mode runs the CPU from the fast clock divided as selected.
// - Slow mode runs from subclock; fast oscillator follows its enable bit.
// - Halt with both keep bits 0 is sleep; only slow oscillator may run, kept by the watchdog.
// - Halt, fast keep 0, slow keep 1: subclock on; system clock only for code 7.
// - Halt with both keep bits 1 keeps all clocks and system clock running.
// - Halt, fast keep 1, slow keep 0: fast on; system clock off for code 7.
// - Slow oscillator stays enabled whenever the watchdog is enabled.
// - Select field switches fast and slow; halt enters mode chosen by keep bits.
// - Frequency codes: 0 is 2 MHz, 1 is 4 MHz, 2 is 8 MHz, 3 is 2 MHz.
// - A new frequency takes effect only once the stable flag is set.
// - Enable or frequency change clears the stable flag until settled.
// - Fast oscillator enable resets to one.
// - Unimplemented register bits read as zero.
// - Restart of the fast oscillator is tracked through the stable flag.
// - Port A falling edge, interrupt or watchdog overflow wakes the device.
`include "scmc_params.svh"
module scmc_top (
    // Clock, reset and clock enable
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic CLK_EN,
    // AXI4-Lite write address and data
    input wire logic [3:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    // AXI4-Lite write response
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    // AXI4-Lite read
    input wire logic [3:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    // Core and wake sources
    input wire logic CPU_HALT,
    input wire logic WDT_ENABLE,
    input wire logic WAKE_PORT_A,
    input wire logic WAKE_IRQ,
    input wire logic WAKE_WDT,
    // Clock enables towards the chip
    output logic CPU_RUN,
    output logic SYSTEM_CLOCK_EN,
    output logic SYSTEM_CLOCK_TICK,
    output logic FAST_CLOCK_EN,
    output logic SUB_CLOCK_EN,
    output logic SLOW_RC_EN,
    output logic FAST_RC_OSC_EN,
    output logic [1:0] FAST_RC_FREQ,
    output logic [2:0] MODE,
    output logic IRQ
);
    // ****************************************************************
    // Registers
    // ****************************************************************
    // Copies of the two control bytes, the settling state and the interrupt pair.
    logic [2:0] sel_ff;
    logic fast_keep_ff;
    logic slow_keep_ff;
    logic [1:0] freq_req_ff;
    logic [1:0] freq_use_ff;
    logic rc_en_ff;
    logic stable_ff;
    logic [8:0] settle_ff;
    logic [1:0] irq_stat_ff;
    logic [1:0] irq_mask_ff;
    scmc_pkg::scmc_mode_t mode_ff;
    scmc_pkg::scmc_mode_t nxt_mode;
    logic [5:0] div_ff;
    logic [2:0] sel_use_ff;
    logic aw_got_ff;
    logic w_got_ff;
    logic [3:0] aw_addr_ff;
    logic [31:0] w_data_ff;
    logic [3:0] w_strb_ff;
    logic port_a_d_ff;
    logic wr_go;
    logic wr_lane0;
    logic [7:0] wb;
    logic restart;
    logic halted;
    logic wake;
    logic [7:0] rd_byte;

    // ****************************************************************
    // AXI4-Lite write path
    // ****************************************************************
    // A write commits once both halves are held and no response is pending.
    assign wr_go = aw_got_ff && w_got_ff && !BVALID;
    assign wr_lane0 = wr_go && w_strb_ff[0];
    assign wb = w_data_ff[7:0];

    // Address and data are latched independently so either may come first.
    // Aligned addresses answer OKAY even where no register lives.
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            aw_addr_ff <= 4'h0;
            w_data_ff <= 32'h0;
            w_strb_ff <= 4'h0;
            AWREADY <= 1'b0;
            WREADY <= 1'b0;
            BVALID <= 1'b0;
            BRESP <= 2'h0;
        end else if (CLK_EN) begin
            AWREADY <= !aw_got_ff && !AWREADY && !BVALID;
            WREADY <= !w_got_ff && !WREADY && !BVALID;
            if (AWVALID && AWREADY) begin
                aw_got_ff <= 1'b1;
                aw_addr_ff <= AWADDR;
            end
            if (WVALID && WREADY) begin
                w_got_ff <= 1'b1;
                w_data_ff <= WDATA;
                w_strb_ff <= WSTRB;
            end
            if (wr_go) begin
                BVALID <= 1'b1;
                BRESP <= (aw_addr_ff[1:0] == 2'h0) ? 2'h0 : 2'h2;
                aw_got_ff <= 1'b0;
                w_got_ff <= 1'b0;
            end else if (BVALID && BREADY) begin
                BVALID <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Control registers
    // ****************************************************************
    // Keep bits only matter during a halt; writing them while running is harmless.
    // Select and keep-alive bits; the select field is the only fast/slow switch.
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            sel_ff <= 3'(`SCMC_SYSCLK_RESET >> `SCMC_SYSCLK_SEL_LSB);
            fast_keep_ff <= 1'b0;
            slow_keep_ff <= 1'b0;
        end else if (CLK_EN && wr_lane0 && aw_addr_ff == `SCMC_OFS_SYSCLK) begin
            sel_ff <= wb[7:5];
            fast_keep_ff <= wb[`SCMC_SYSCLK_FAST_KEEP];
            slow_keep_ff <= wb[`SCMC_SYSCLK_SLOW_KEEP];
        end
    end

    // A restart is any rising enable or a frequency change while enabled.
    assign restart = wr_lane0 && aw_addr_ff == `SCMC_OFS_FASTRC && wb[`SCMC_FASTRC_ENABLE]
        && (!rc_en_ff || wb[3:2] != freq_req_ff);

    // Oscillator enable resets high so the fast clock runs after power-on.
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            rc_en_ff <= 1'b1;
            freq_req_ff <= 2'h0;
        end else if (CLK_EN && wr_lane0 && aw_addr_ff == `SCMC_OFS_FASTRC) begin
            rc_en_ff <= wb[`SCMC_FASTRC_ENABLE];
            freq_req_ff <= wb[3:2];
        end
    end

    // The settle count is fixed and short; a slower oscillator would need a larger count.
    // Settling counter; the applied frequency follows the request only when stable.
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            stable_ff <= 1'b0;
            settle_ff <= 9'(`SCMC_SETTLE_CYC);
            freq_use_ff <= 2'h0;
        end else if (CLK_EN) begin
            if (restart) begin
                stable_ff <= 1'b0;
                settle_ff <= 9'(`SCMC_SETTLE_CYC);
            end else if (!rc_en_ff) begin
                stable_ff <= 1'b0;
            end else if (settle_ff != 9'h0) begin
                settle_ff <= settle_ff - 9'h1;
            end else begin
                stable_ff <= 1'b1;
                freq_use_ff <= freq_req_ff;
            end
        end
    end

    // ****************************************************************
    // Operating mode
    // ****************************************************************
    // A pin held low wakes only once, as the edge is taken against the last sample.
    assign halted = mode_ff != scmc_pkg::SCMC_FAST && mode_ff != scmc_pkg::SCMC_SLOW;
    assign wake = WAKE_IRQ || WAKE_WDT || (port_a_d_ff && !WAKE_PORT_A);

    // Halt picks the low-power mode from the keep bits of that moment.
    always_comb begin
        nxt_mode = mode_ff;
        if (halted) begin
            if (wake) begin
                nxt_mode = (sel_ff == `SCMC_SEL_SUB) ? scmc_pkg::SCMC_SLOW : scmc_pkg::SCMC_FAST;
            end
        end else if (CPU_HALT) begin
            unique case ({fast_keep_ff, slow_keep_ff})
                2'b00: nxt_mode = scmc_pkg::SCMC_SLEEP;
                2'b01: nxt_mode = scmc_pkg::SCMC_IDLE_SUB;
                2'b11: nxt_mode = scmc_pkg::SCMC_IDLE_BOTH;
                2'b10: nxt_mode = scmc_pkg::SCMC_IDLE_FAST;
            endcase
        end else begin
            nxt_mode = (sel_ff == `SCMC_SEL_SUB) ? scmc_pkg::SCMC_SLOW : scmc_pkg::SCMC_FAST;
        end
    end

    // Mode register and wake edge tracking.
    // The tracker resets to the idle high level so no false wake follows reset.
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            mode_ff <= scmc_pkg::SCMC_FAST;
            port_a_d_ff <= 1'b1;
        end else if (CLK_EN) begin
            mode_ff <= nxt_mode;
            port_a_d_ff <= WAKE_PORT_A;
        end
    end

    // ****************************************************************
    // Clock division
    // ****************************************************************
    // The divide ratio changes only when the counter wraps, so each output
    // period is whole; a mid-period switch would leave a runt phase.
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            div_ff <= 6'h0;
            sel_use_ff <= 3'h0;
            SYSTEM_CLOCK_TICK <= 1'b0;
        end else if (CLK_EN) begin
            if (sel_use_ff == `SCMC_SEL_SUB || div_ff == ((6'h1 << sel_use_ff) - 6'h1)) begin
                div_ff <= 6'h0;
                sel_use_ff <= sel_ff;
                SYSTEM_CLOCK_TICK <= sel_use_ff != `SCMC_SEL_SUB;
            end else begin
                div_ff <= div_ff + 6'h1;
                SYSTEM_CLOCK_TICK <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Clock enable outputs
    // ****************************************************************
    // Each mode gates the four clocks as the mode table demands.
    // The slow oscillator runs in every mode but sleep, where the watchdog may keep it.
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            CPU_RUN <= 1'b1;
            SYSTEM_CLOCK_EN <= 1'b1;
            FAST_CLOCK_EN <= 1'b1;
            SUB_CLOCK_EN <= 1'b1;
            SLOW_RC_EN <= 1'b1;
        end else if (CLK_EN) begin
            CPU_RUN <= !halted;
            SLOW_RC_EN <= 1'b1;
            unique case (mode_ff)
                scmc_pkg::SCMC_FAST: begin
                    SYSTEM_CLOCK_EN <= 1'b1;
                    FAST_CLOCK_EN <= 1'b1;
                    SUB_CLOCK_EN <= 1'b1;
                end
                scmc_pkg::SCMC_SLOW: begin
                    SYSTEM_CLOCK_EN <= 1'b1;
                    FAST_CLOCK_EN <= rc_en_ff;
                    SUB_CLOCK_EN <= 1'b1;
                end
                scmc_pkg::SCMC_IDLE_SUB: begin
                    SYSTEM_CLOCK_EN <= sel_ff == `SCMC_SEL_SUB;
                    FAST_CLOCK_EN <= 1'b0;
                    SUB_CLOCK_EN <= 1'b1;
                end
                scmc_pkg::SCMC_IDLE_BOTH: begin
                    SYSTEM_CLOCK_EN <= 1'b1;
                    FAST_CLOCK_EN <= 1'b1;
                    SUB_CLOCK_EN <= 1'b1;
                end
                scmc_pkg::SCMC_IDLE_FAST: begin
                    SYSTEM_CLOCK_EN <= sel_ff != `SCMC_SEL_SUB;
                    FAST_CLOCK_EN <= 1'b1;
                    SUB_CLOCK_EN <= 1'b0;
                end
                scmc_pkg::SCMC_SLEEP: begin
                    SYSTEM_CLOCK_EN <= 1'b0;
                    FAST_CLOCK_EN <= 1'b0;
                    SUB_CLOCK_EN <= 1'b0;
                    SLOW_RC_EN <= slow_keep_ff || WDT_ENABLE;
                end
            endcase
        end
    end

    // The oscillator pin follows its enable bit, but a halt without fast keep stops it too.
    // Oscillator pins; code 3 is driven as 2 MHz like code 0.
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            FAST_RC_OSC_EN <= 1'b1;
            FAST_RC_FREQ <= 2'h0;
            MODE <= 3'h0;
        end else if (CLK_EN) begin
            FAST_RC_OSC_EN <= rc_en_ff && (!halted || fast_keep_ff);
            FAST_RC_FREQ <= (freq_use_ff == 2'h3) ? 2'h0 : freq_use_ff;
            MODE <= mode_ff;
        end
    end

    // ****************************************************************
    // Interrupts
    // ****************************************************************
    // Sticky events; a set in the same cycle as a write-one clear wins.
    // Bit 0 marks the oscillator settling, bit 1 a wake from any halt mode.
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            irq_stat_ff <= 2'h0;
            irq_mask_ff <= 2'h0;
            IRQ <= 1'b0;
        end else if (CLK_EN) begin
            if (wr_lane0 && aw_addr_ff == `SCMC_OFS_IRQ_MASK) begin
                irq_mask_ff <= wb[1:0];
            end
            irq_stat_ff <= (irq_stat_ff
                & ~((wr_lane0 && aw_addr_ff == `SCMC_OFS_IRQ_STATUS) ? wb[1:0] : 2'h0))
                | {halted && wake, rc_en_ff && !restart && settle_ff == 9'h0 && !stable_ff};
            IRQ <= |(irq_stat_ff & irq_mask_ff);
        end
    end

    // ****************************************************************
    // AXI4-Lite read path
    // ****************************************************************
    // Unimplemented bits read as zero.
    // Only the low byte carries registers; the upper bytes always read as zero.
    always_comb begin
        unique case (ARADDR)
            `SCMC_OFS_SYSCLK: rd_byte = {sel_ff, 3'h0, fast_keep_ff, slow_keep_ff};
            `SCMC_OFS_FASTRC: rd_byte = {4'h0, freq_req_ff, stable_ff, rc_en_ff};
            `SCMC_OFS_IRQ_STATUS: rd_byte = {6'h0, irq_stat_ff};
            `SCMC_OFS_IRQ_MASK: rd_byte = {6'h0, irq_mask_ff};
            default: rd_byte = 8'h00;
        endcase
    end

    // One read at a time; misaligned addresses answer SLVERR.
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            ARREADY <= 1'b0;
            RVALID <= 1'b0;
            RDATA <= 32'h0;
            RRESP <= 2'h0;
        end else if (CLK_EN) begin
            ARREADY <= !RVALID && !ARREADY;
            if (ARVALID && ARREADY) begin
                RVALID <= 1'b1;
                RDATA <= {24'h0, rd_byte};
                RRESP <= (ARADDR[1:0] == 2'h0) ? 2'h0 : 2'h2;
            end else if (RVALID && RREADY) begin
                RVALID <= 1'b0;
            end
        end
    end
endmodule

// >>> verification/scmc_core_model.sv
// Behavioural model of the core that executes halt.
// Assumes CLOCK is the block clock and CPU_RUN its run indication.
module scmc_core_model (
    // Clock and run status
    input wire logic CLOCK,
    input wire logic CPU_RUN,
    // Halt request
    output logic CPU_HALT
);
    timeunit 1ns;
    timeprecision 1ns;
    initial CPU_HALT = 1'b0;
    // Halt after a lag and hold it until the core is seen stopped.
    // The mode is picked from the keep bits at this moment, not earlier.
    task automatic halt(input int lag);
        repeat (lag) @(posedge CLOCK);
        CPU_HALT <= 1'b1;
        do @(posedge CLOCK); while (CPU_RUN !== 1'b0);
        CPU_HALT <= 1'b0;
    endtask
endmodule

// >>> verification/scmc_props_properties.sv
// Concurrent checks on the mode and clock enable ports.
// Assumes it is bound into scmc_top and sees only its ports.
module scmc_props (
    // Clock, reset and core inputs
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic CPU_HALT,
    input wire logic WDT_ENABLE,
    input wire logic WAKE_IRQ,
    input wire logic WAKE_WDT,
    // Observed outputs
    input wire logic CPU_RUN,
    input wire logic SYSTEM_CLOCK_EN,
    input wire logic FAST_CLOCK_EN,
    input wire logic SUB_CLOCK_EN,
    input wire logic SLOW_RC_EN,
    input wire logic FAST_RC_OSC_EN,
    input wire logic [2:0] MODE
);
    // *******
    // Checks
    // *******
    logic [2:0] last_mode_ff;
    logic held;
    // Enables change on the same edge as the mode; a mode is judged only once it has held.
    always_ff @(posedge CLOCK) last_mode_ff <= MODE;
    assign held = MODE == last_mode_ff;
    // One domain; run modes are the codes whose two upper bits are zero.
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RST_N);
    property p_rst;
        $rose(RST_N) |-> FAST_RC_OSC_EN && CPU_RUN && MODE == 3'h0;
    endproperty
    a_rst: assert property (p_rst) else $error("Bad values after reset.");
    property p_slp;
        held && MODE == 3'h7 |-> !(CPU_RUN || SYSTEM_CLOCK_EN || FAST_CLOCK_EN || SUB_CLOCK_EN);
    endproperty
    a_slp: assert property (p_slp) else $error("Clock on in sleep.");
    property p_sub;
        held && MODE == 3'h3 |-> SUB_CLOCK_EN && !FAST_CLOCK_EN && !CPU_RUN;
    endproperty
    a_sub: assert property (p_sub) else $error("Bad subclock idle.");
    property p_both;
        held && MODE == 3'h2 |-> FAST_CLOCK_EN && SUB_CLOCK_EN && SYSTEM_CLOCK_EN;
    endproperty
    a_both: assert property (p_both) else $error("Bad two clock idle.");
    property p_fst;
        held && MODE == 3'h6 |-> FAST_CLOCK_EN && !SUB_CLOCK_EN;
    endproperty
    a_fst: assert property (p_fst) else $error("Bad fast clock idle.");
    property p_wdt;
        WDT_ENABLE [*3] |-> SLOW_RC_EN;
    endproperty
    a_wdt: assert property (p_wdt) else $error("Slow oscillator off.");
    // The mode register and the run output both follow a request by two edges.
    property p_halt;
        MODE[2:1] == 2'h0 && CPU_HALT && !WAKE_IRQ && !WAKE_WDT
            |-> ##2 MODE[2:1] != 2'h0 && !CPU_RUN;
    endproperty
    a_halt: assert property (p_halt) else $error("Halt not taken.");
    property p_wake;
        MODE[2:1] != 2'h0 && (WAKE_IRQ || WAKE_WDT) |-> ##2 MODE[2:1] == 2'h0 && CPU_RUN;
    endproperty
    a_wake: assert property (p_wake) else $error("Wake not taken.");
endmodule

bind scmc_top scmc_props u_scmc_props (.CLOCK(CLOCK), .RST_N(RST_N), .CPU_HALT(CPU_HALT),
    .WDT_ENABLE(WDT_ENABLE), .WAKE_IRQ(WAKE_IRQ), .WAKE_WDT(WAKE_WDT), .CPU_RUN(CPU_RUN),
    .SYSTEM_CLOCK_EN(SYSTEM_CLOCK_EN), .FAST_CLOCK_EN(FAST_CLOCK_EN), .MODE(MODE),
    .SUB_CLOCK_EN(SUB_CLOCK_EN), .SLOW_RC_EN(SLOW_RC_EN), .FAST_RC_OSC_EN(FAST_RC_OSC_EN));

// >>> verification/scmc_top_test.sv
// Self-checking bench for the clock mode control block.
// Assumes the core model issues halts; the bench is the register master.
`include "scmc_params.svh"
module scmc_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    // *******
    // Signals
    // *******
    logic CLOCK = 1'b0;
    logic CLK_EN = 1'b1;
    logic RST_N, AWVALID, WVALID, BREADY, ARVALID, RREADY, AWREADY, WREADY, BVALID;
    logic ARREADY, RVALID, CPU_HALT, WDT_ENABLE, WAKE_PORT_A, WAKE_IRQ, WAKE_WDT, IRQ;
    logic CPU_RUN, SYSTEM_CLOCK_EN, SYSTEM_CLOCK_TICK, FAST_CLOCK_EN, SUB_CLOCK_EN;
    logic SLOW_RC_EN, FAST_RC_OSC_EN;
    logic [3:0] AWADDR, ARADDR;
    logic [31:0] WDATA, RDATA, d;
    logic [1:0] BRESP, RRESP, FAST_RC_FREQ, r, k;
    logic [2:0] MODE, s;
    int err_total = 0;
    int samples_checked = 0;
    int seed = 81;
    int g;
    int i;
    // Clock; byte enables stay fixed, so only the low byte lane is ever written.
    always #25 CLOCK = ~CLOCK;
    scmc_top u_scmc_top (.WSTRB(4'h1), .*);
    scmc_core_model u_scmc_core_model (.CLOCK(CLOCK), .CPU_RUN(CPU_RUN), .CPU_HALT(CPU_HALT));
    // Bus cycles: hold each channel until its ready, keep the response ready up.
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge CLOCK);
        AWADDR <= a;
        WDATA <= v;
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        BREADY <= 1'b1;
        do begin
            @(posedge CLOCK);
            if (AWREADY) AWVALID <= 1'b0;
            if (WREADY) WVALID <= 1'b0;
        end while (BVALID !== 1'b1);
        r = BRESP;
        BREADY <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge CLOCK);
        ARADDR <= a;
        ARVALID <= 1'b1;
        RREADY <= 1'b1;
        do begin
            @(posedge CLOCK);
            if (ARREADY) ARVALID <= 1'b0;
        end while (RVALID !== 1'b1);
        d = RDATA;
        r = RRESP;
        RREADY <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Poll until the oscillator reports settled; the watchdog bounds it.
    task automatic stab;
        do rd(`SCMC_OFS_FASTRC); while (d[1] !== 1'b1);
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Expected values from the keep bits, select code and frequency code.
    function automatic scmc_pkg::scmc_mode_t hmode(logic [1:0] kk);
        case (kk)
            2'b00: return scmc_pkg::SCMC_SLEEP;
            2'b01: return scmc_pkg::SCMC_IDLE_SUB;
            2'b10: return scmc_pkg::SCMC_IDLE_FAST;
            default: return scmc_pkg::SCMC_IDLE_BOTH;
        endcase
    endfunction
    function automatic logic sys_on(logic [1:0] kk, logic [2:0] ss);
        case (kk)
            2'b00: return 1'b0;
            2'b01: return ss == 3'h7;
            2'b10: return ss != 3'h7;
            default: return 1'b1;
        endcase
    endfunction
    function automatic logic [1:0] fmap(int c);
        return (c == 3) ? 2'h0 : 2'(c);
    endfunction
    // Watchdog, well beyond the few thousand cycles the run needs.
    initial begin
        #2000000;
        err_total++;
        wrap_up();
    end
    // *******
    // Tests
    // *******
    initial begin
        {RST_N, AWVALID, WVALID, BREADY, ARVALID, RREADY, WAKE_IRQ, WAKE_WDT} = '0;
        {AWADDR, ARADDR, WDATA, WDT_ENABLE} = '0;
        WAKE_PORT_A = 1'b1;
        repeat (8) @(posedge CLOCK);
        RST_N <= 1'b1;
        rd(`SCMC_OFS_SYSCLK);
        chk(d, 32'h0);
        rd(`SCMC_OFS_FASTRC);
        chk(d, 32'h1);
        stab();
        chk(d, 32'h3);
        // Settling raises the status bit; the interrupt follows the mask.
        rd(`SCMC_OFS_IRQ_STATUS);
        chk(d, 32'h1);
        chk(IRQ, 1'b0);
        wr(`SCMC_OFS_IRQ_MASK, 32'h1);
        repeat (2) @(posedge CLOCK);
        chk(IRQ, 1'b1);
        wr(`SCMC_OFS_IRQ_STATUS, 32'h1);
        repeat (2) @(posedge CLOCK);
        chk(IRQ, 1'b0);
        wr(4'h2, 32'hFF);
        chk(r, 2'h2);
        rd(4'h1);
        chk(r, 2'h2);
        // Every frequency code, with random junk in the unimplemented bits.
        for (i = 1; i < 5; i++) begin
            d = $random(seed);
            d[3:0] = {2'(i % 4), 2'b01};
            wr(`SCMC_OFS_FASTRC, d);
            rd(`SCMC_OFS_FASTRC);
            chk(d, 32'({2'(i % 4), 2'b01}));
            chk(FAST_RC_FREQ, fmap(i - 1));
            stab();
            chk(FAST_RC_FREQ, fmap(i % 4));
        end
        // Divide ratios: gap between ticks once the divider has wrapped.
        for (i = 0; i < 7; i++) begin
            wr(`SCMC_OFS_SYSCLK, 32'(i << 5));
            repeat (3) do @(posedge CLOCK); while (SYSTEM_CLOCK_TICK !== 1'b1);
            g = 0;
            do begin
                @(posedge CLOCK);
                g++;
            end while (SYSTEM_CLOCK_TICK !== 1'b1);
            chk(g, 1 << i);
            chk(32'(MODE), 32'(scmc_pkg::SCMC_FAST));
        end
        wr(`SCMC_OFS_SYSCLK, 32'hE0);
        // Once the old ratio has run out, the subclock select gives no ticks and the mode reads slow.
        repeat (70) @(posedge CLOCK);
        g = 0;
        repeat (70) @(posedge CLOCK) g += SYSTEM_CLOCK_TICK;
        chk(g, 0);
        chk(32'(MODE), 32'(scmc_pkg::SCMC_SLOW));
        wr(`SCMC_OFS_FASTRC, 32'h0);
        repeat (3) @(posedge CLOCK);
        chk(FAST_RC_OSC_EN, 1'b0);
        chk(FAST_CLOCK_EN, 1'b0);
        wr(`SCMC_OFS_FASTRC, 32'h1);
        // A frozen block must not count down the settling time.
        CLK_EN <= 1'b0;
        repeat (400) @(posedge CLOCK);
        CLK_EN <= 1'b1;
        rd(`SCMC_OFS_FASTRC);
        chk(d, 32'h1);
        stab();
        chk(FAST_RC_OSC_EN, 1'b1);
        // Each keep setting with a fast and a sub select, then each wake source.
        for (i = 0; i < 8; i++) begin
            k = 2'(i >> 1);
            s = i[0] ? 3'h7 : 3'($unsigned($random(seed)) % 7);
            WDT_ENABLE <= 1'($random(seed));
            wr(`SCMC_OFS_SYSCLK, 32'({s, 3'h0, k}));
            u_scmc_core_model.halt($unsigned($random(seed)) % 4);
            repeat (2) @(posedge CLOCK);
            chk(32'(MODE), 32'(hmode(k)));
            chk(SYSTEM_CLOCK_EN, sys_on(k, s));
            chk({FAST_CLOCK_EN, SUB_CLOCK_EN, FAST_RC_OSC_EN}, {k, k[1]});
            chk(SLOW_RC_EN, k != 0 || WDT_ENABLE);
            case (i % 3)
                0: WAKE_IRQ <= 1'b1;
                1: WAKE_WDT <= 1'b1;
                default: WAKE_PORT_A <= 1'b0;
            endcase
            repeat (2) @(posedge CLOCK);
            {WAKE_IRQ, WAKE_WDT, WAKE_PORT_A} <= 3'b001;
            repeat (3) @(posedge CLOCK);
            chk(MODE, (s == 3'h7) ? scmc_pkg::SCMC_SLOW : scmc_pkg::SCMC_FAST);
        end
        wrap_up();
    end
endmodule
